// File: hsfs_pkg.sv
// Shared constants and types for the high-side switch fault sequencer.
// Assumes a 125 MHz system clock; every cycle count is derived from it.
package hsfs_pkg;

  // System clock rate, used to turn times into cycle counts.
  localparam int CLK_MHZ = 125;

  // Deglitch and sequencing times in nanoseconds.
  localparam int CUR_LIMIT_DEGLITCH_NS = 2500;
  localparam int REL_TEMP_DEGLITCH_NS = 2500;
  localparam int ABS_TEMP_DEGLITCH_NS = 20000;
  localparam int OPEN_LOAD_DEGLITCH_NS = 700000;
  localparam int RETRY_WAIT_TIME_NS = 1000000;
  localparam int FAST_TRIP_OFF_NS = 64;

  // Least times round up to whole cycles.
  function automatic int ns_to_cyc(input int ns);
    int cyc;
    cyc = (ns * CLK_MHZ + 999) / 1000;
    return (cyc < 1) ? 1 : cyc;
  endfunction : ns_to_cyc

  localparam int CUR_LIMIT_CYC = ns_to_cyc(CUR_LIMIT_DEGLITCH_NS);
  localparam int REL_TEMP_CYC = ns_to_cyc(REL_TEMP_DEGLITCH_NS);
  localparam int ABS_TEMP_CYC = ns_to_cyc(ABS_TEMP_DEGLITCH_NS);
  localparam int OPEN_LOAD_CYC = ns_to_cyc(OPEN_LOAD_DEGLITCH_NS);
  localparam int RETRY_CYC = ns_to_cyc(RETRY_WAIT_TIME_NS);
  localparam int TRIP_CYC = ns_to_cyc(FAST_TRIP_OFF_NS);

  // Register map, byte addresses on the Avalon slave.
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic CTRL_RST = 1'b0;

  // Control and status field positions.
  localparam int CTRL_SW_DISABLE = 0;
  localparam int ST_CHAN_ON = 0;
  localparam int ST_CLAMP = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_OPEN_LOAD = 3;
  localparam int ST_ABS_PEND = 4;
  localparam int ST_LATCHED = 5;
  localparam int ST_REL_Q = 6;
  localparam int ST_ABS_Q = 7;
  localparam int ST_LIMIT_Q = 8;
  localparam int ST_FLAG_PIN = 9;

  // Bit positions in the synchronised input vector.
  localparam int IN_W = 10;
  localparam int IN_ENABLE = 0;
  localparam int IN_INHIBIT = 1;
  localparam int IN_REPORT = 2;
  localparam int IN_CUR_LIMIT = 3;
  localparam int IN_FAST_TRIP = 4;
  localparam int IN_REL_TEMP = 5;
  localparam int IN_ABS_TEMP = 6;
  localparam int IN_BELOW_HYS = 7;
  localparam int IN_OPEN_LOAD = 8;
  localparam int IN_FLAG_PIN = 9;

  // Channel sequencing states.
  typedef enum logic [2:0] {
    HSFS_OFF,
    HSFS_ON,
    HSFS_TRIP,
    HSFS_LIMIT,
    HSFS_RETRY,
    HSFS_LATCHED
  } hsfs_state_t;

endpackage : hsfs_pkg

// File: hsfs_sync.sv
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/100ps
module hsfs_sync #(
  parameter int W = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = i_clk_en ? i_async : meta;
    next_sync = i_clk_en ? meta : o_sync;
  end

  // Register both stages.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end

endmodule : hsfs_sync

// File: hsfs_deglitch.sv
// Deglitch filter: the output rises only after the condition has held for
// COUNT consecutive enabled cycles and drops in the cycle after it goes away.
// Assumes i_cond is already synchronous to i_sys_clk.
`timescale 1ns/100ps
module hsfs_deglitch #(
  parameter int COUNT = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_cond,
  output logic o_qual
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_qual;
  logic [CW-1:0] run_len;

  // restart on drop: any gap resets the count.
  always_comb begin
    next_cnt = cnt;
    next_qual = o_qual;
    if (i_clk_en) begin
      if (!i_cond) begin
        next_cnt = '0;
        next_qual = 1'b0;
      end else if (cnt == LAST) begin
        next_qual = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Register the counter and the qualified output.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt <= '0;
      o_qual <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_qual <= next_qual;
    end
  end

  // Helper that measures how long the condition has held, for checking only.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !i_cond) begin
      run_len <= '0;
    end else if (i_clk_en && run_len != CW'(COUNT)) begin
      run_len <= run_len + 1'b1;
    end
  end

  a_qual_min_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(o_qual) |-> run_len == CW'(COUNT))
    else $error("Fault qualified before its deglitch time.");

  a_drop_clears: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_clk_en && !i_cond) |=> !o_qual)
    else $error("Qualified fault did not drop with its condition.");

endmodule : hsfs_deglitch

// File: hsfs_top.sv
// Fault sequencer of a single-channel high-side switch: deglitching, current
// limit, fast trip, thermal retry or latch-off, open-load flagging, reporting.
// Assumes pin and comparator inputs are asynchronous, and an Avalon-MM master
// on i_sys_clk. The analog stage acts on o_channel_on and o_current_clamp.
//
// Function
// - Deglitch: limit and relative 2.5 us, absolute 20 us, open load 700 us.
// - Start current limiting after the overload deglitch, then regulate.
// - Keep clamping until thermal shutdown or overload goes away.
// - Fast trip from full on: brief off, then clamp at limit.
// - Shut down on relative overtemperature.
// - Relative shutdown with inhibit low: wait retry time, turn on.
// - Absolute shutdown: wait for cooling below hysteresis and retry time.
// - Inhibit high: stay off until inhibit or enable toggles.
// - Leaving latch-off with inhibit low: resume in auto-retry.
// - Leaving latch-off with inhibit high: next fault latches off again.
// - During limit or thermal fault hold flag low, sense high.
// - Protection never depends on the report enable.
// - Off-state open load pulls flag low and raises sense.
// - Connect the off-state pull-up only while reporting is enabled.
// - Short-to-battery shares the open-load path and indication.
// - Report enable low puts flag and sense in high impedance.
// - Off-state open-load indication clears when the condition ends.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module hsfs_top #(
  parameter int OPEN_LOAD_CYC = hsfs_pkg::OPEN_LOAD_CYC,
  parameter int RETRY_CYC = hsfs_pkg::RETRY_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_enable,
  input wire logic i_retry_inhibit,
  input wire logic i_fault_report_enable,
  input wire logic i_current_limit_event,
  input wire logic i_fast_trip_threshold,
  input wire logic i_relative_overtemp,
  input wire logic i_absolute_overtemp,
  input wire logic i_below_hysteresis,
  input wire logic i_open_load,
  input wire logic i_fault_flag_n,
  input wire logic [hsfs_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_channel_on,
  output logic o_current_clamp,
  output logic o_pullup_on,
  output logic o_fault_flag_n,
  output logic o_fault_flag_n_oe,
  output logic o_sense_fault_high,
  output logic o_sense_oe
);

  localparam int RW = $clog2(RETRY_CYC + 1);
  localparam int TW = $clog2(hsfs_pkg::TRIP_CYC + 1);
  localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_CYC - 1);
  localparam logic [TW-1:0] TRIP_LAST = TW'(hsfs_pkg::TRIP_CYC - 1);

  // States in which a limit or thermal fault is being reported.
  function automatic logic is_fault(input hsfs_pkg::hsfs_state_t s);
    return (s == hsfs_pkg::HSFS_LIMIT) || (s == hsfs_pkg::HSFS_TRIP) ||
           (s == hsfs_pkg::HSFS_RETRY) || (s == hsfs_pkg::HSFS_LATCHED);
  endfunction : is_fault

  // States in which the power transistor conducts.
  function automatic logic is_driving(input hsfs_pkg::hsfs_state_t s);
    return (s == hsfs_pkg::HSFS_ON) || (s == hsfs_pkg::HSFS_LIMIT);
  endfunction : is_driving

  logic [hsfs_pkg::IN_W-1:0] raw_in;
  logic [hsfs_pkg::IN_W-1:0] syn;
  logic en_s;
  logic inhib_s;
  logic rep_s;
  logic below_s;
  logic cle_q;
  logic rel_q;
  logic abs_q;
  logic ol_q;
  logic ol_cond;
  logic therm_q;
  logic run;
  logic inhib_prev;
  logic inhib_fell;
  hsfs_pkg::hsfs_state_t state;
  hsfs_pkg::hsfs_state_t next_state;
  logic [RW-1:0] retry_cnt;
  logic [RW-1:0] next_retry_cnt;
  logic [TW-1:0] trip_cnt;
  logic [TW-1:0] next_trip_cnt;
  logic abs_pend;
  logic next_abs_pend;
  logic next_chan;
  logic next_fault;
  logic sw_disable;
  logic next_sw_disable;
  logic next_wait;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic req;
  logic [TW:0] trip_len;

  // Every pin and comparator crosses two flops before any logic sees it.
  assign raw_in = {i_fault_flag_n, i_open_load, i_below_hysteresis, i_absolute_overtemp,
                   i_relative_overtemp, i_fast_trip_threshold, i_current_limit_event,
                   i_fault_report_enable, i_retry_inhibit, i_enable};

  hsfs_sync #(
    .W(hsfs_pkg::IN_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_async(raw_in),
    .o_sync(syn)
  );

  // Named views of the synchronised inputs.
  assign en_s = syn[hsfs_pkg::IN_ENABLE];
  assign inhib_s = syn[hsfs_pkg::IN_INHIBIT];
  assign rep_s = syn[hsfs_pkg::IN_REPORT];
  assign below_s = syn[hsfs_pkg::IN_BELOW_HYS];

  hsfs_deglitch #(
    .COUNT(hsfs_pkg::CUR_LIMIT_CYC)
  ) u_dg_limit (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_cond(syn[hsfs_pkg::IN_CUR_LIMIT]),
    .o_qual(cle_q)
  );

  hsfs_deglitch #(
    .COUNT(hsfs_pkg::REL_TEMP_CYC)
  ) u_dg_rel (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_cond(syn[hsfs_pkg::IN_REL_TEMP]),
    .o_qual(rel_q)
  );

  hsfs_deglitch #(
    .COUNT(hsfs_pkg::ABS_TEMP_CYC)
  ) u_dg_abs (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_cond(syn[hsfs_pkg::IN_ABS_TEMP]),
    .o_qual(abs_q)
  );

  // one comparator covers open load and short-to-battery alike.
  // The off-state check needs the pull-up, so it only runs while reporting.
  assign ol_cond = syn[hsfs_pkg::IN_OPEN_LOAD] && rep_s && !o_channel_on;

  hsfs_deglitch #(
    .COUNT(OPEN_LOAD_CYC)
  ) u_dg_open (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_cond(ol_cond),
    .o_qual(ol_q)
  );

  // either thermal fault shuts the channel down.
  assign therm_q = rel_q || abs_q;
  assign run = en_s && !sw_disable;
  assign inhib_fell = inhib_prev && !inhib_s;

  // Channel sequencer. The report enable is deliberately absent here.
  // protection ignores report enable.
  always_comb begin
    next_state = state;
    next_retry_cnt = retry_cnt;
    next_trip_cnt = trip_cnt;
    next_abs_pend = abs_pend;
    if (therm_q && (is_driving(state) || state == hsfs_pkg::HSFS_TRIP)) begin
      next_state = hsfs_pkg::HSFS_RETRY;
      next_retry_cnt = RETRY_LAST;
      next_abs_pend = abs_q;
    end else begin
      unique case (state)
        hsfs_pkg::HSFS_OFF: begin
          if (run) begin
            next_state = hsfs_pkg::HSFS_ON;
          end
        end
        hsfs_pkg::HSFS_ON: begin
          if (!run) begin
            next_state = hsfs_pkg::HSFS_OFF;
          end else if (syn[hsfs_pkg::IN_FAST_TRIP]) begin
            next_state = hsfs_pkg::HSFS_TRIP;
            next_trip_cnt = TRIP_LAST;
          end else if (cle_q) begin
            next_state = hsfs_pkg::HSFS_LIMIT;
          end
        end
        hsfs_pkg::HSFS_TRIP: begin
          if (!run) begin
            next_state = hsfs_pkg::HSFS_OFF;
          end else if (trip_cnt == '0) begin
            next_state = hsfs_pkg::HSFS_LIMIT;
          end else begin
            next_trip_cnt = trip_cnt - 1'b1;
          end
        end
        hsfs_pkg::HSFS_LIMIT: begin
          // clamp until the comparator clears, also after a fast trip.
          if (!run) begin
            next_state = hsfs_pkg::HSFS_OFF;
          end else if (!syn[hsfs_pkg::IN_CUR_LIMIT]) begin
            next_state = hsfs_pkg::HSFS_ON;
          end
        end
        hsfs_pkg::HSFS_RETRY: begin
          if (abs_q) begin
            next_abs_pend = 1'b1;
          end
          if (retry_cnt != '0) begin
            next_retry_cnt = retry_cnt - 1'b1;
          // absolute shutdown also waits for cooling.
          end else if (!abs_pend || below_s) begin
            next_abs_pend = 1'b0;
            if (!run) begin
              next_state = hsfs_pkg::HSFS_OFF;
            // inhibit high latches the channel off.
            end else if (inhib_s) begin
              next_state = hsfs_pkg::HSFS_LATCHED;
            end else begin
              next_state = hsfs_pkg::HSFS_ON;
            end
          end
        end
        hsfs_pkg::HSFS_LATCHED: begin
          // inhibit released with enable high resumes auto-retry.
          if (!en_s) begin
            next_state = hsfs_pkg::HSFS_OFF;
          end else if (inhib_fell && run) begin
            next_state = hsfs_pkg::HSFS_ON;
          end
        end
      endcase
    end
    if (!i_clk_en) begin
      next_state = state;
      next_retry_cnt = retry_cnt;
      next_trip_cnt = trip_cnt;
      next_abs_pend = abs_pend;
    end
  end

  // reset clears fault state and timers.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= hsfs_pkg::HSFS_OFF;
      retry_cnt <= '0;
      trip_cnt <= '0;
      abs_pend <= 1'b0;
      inhib_prev <= 1'b0;
    end else begin
      state <= next_state;
      retry_cnt <= next_retry_cnt;
      trip_cnt <= next_trip_cnt;
      abs_pend <= next_abs_pend;
      inhib_prev <= i_clk_en ? inhib_s : inhib_prev;
    end
  end

  // Outputs are registered from the next state so they line up with it.
  // latch mode is its own state, HSFS_LATCHED, entered from RETRY with inhibit still high.
  assign next_chan = is_driving(next_state);
  assign next_fault = is_fault(next_state) || ol_q;

  // Reporting outputs; the flag pin only ever drives low.
  // report enable low floats flag and sense.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_channel_on <= 1'b0;
      o_current_clamp <= 1'b0;
      o_pullup_on <= 1'b0;
      o_fault_flag_n <= 1'b0;
      o_fault_flag_n_oe <= 1'b0;
      o_sense_fault_high <= 1'b0;
      o_sense_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_channel_on <= next_chan;
      o_current_clamp <= (next_state == hsfs_pkg::HSFS_LIMIT);
      // pull-up only with reporting on and the channel off.
      o_pullup_on <= rep_s && !next_chan;
      o_fault_flag_n <= 1'b0;
      o_fault_flag_n_oe <= rep_s && next_fault;
      o_sense_fault_high <= rep_s && next_fault;
      o_sense_oe <= rep_s;
    end
  end

  // Status word showing the sequencer's own state.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hsfs_pkg::ST_CHAN_ON] = o_channel_on;
    status_word[hsfs_pkg::ST_CLAMP] = o_current_clamp;
    status_word[hsfs_pkg::ST_FAULT] = is_fault(state) || ol_q;
    status_word[hsfs_pkg::ST_OPEN_LOAD] = ol_q;
    status_word[hsfs_pkg::ST_ABS_PEND] = abs_pend;
    status_word[hsfs_pkg::ST_LATCHED] = (state == hsfs_pkg::HSFS_LATCHED);
    status_word[hsfs_pkg::ST_REL_Q] = rel_q;
    status_word[hsfs_pkg::ST_ABS_Q] = abs_q;
    status_word[hsfs_pkg::ST_LIMIT_Q] = cle_q;
    status_word[hsfs_pkg::ST_FLAG_PIN] = syn[hsfs_pkg::IN_FLAG_PIN];
  end

  // Avalon slave: one wait cycle per access, then completion with wait low.
  // Unmapped reads return zero and unmapped writes are dropped.
  assign req = i_avs_read || i_avs_write;

  always_comb begin
    next_wait = o_avs_waitrequest;
    next_rdata = o_avs_readdata;
    next_sw_disable = sw_disable;
    if (i_clk_en) begin
      next_wait = !(req && o_avs_waitrequest);
      if (req && o_avs_waitrequest) begin
        next_rdata = 32'h0000_0000;
        if (i_avs_address == hsfs_pkg::ADDR_CTRL) begin
          next_rdata[hsfs_pkg::CTRL_SW_DISABLE] = sw_disable;
        end else if (i_avs_address == hsfs_pkg::ADDR_STATUS) begin
          next_rdata = status_word;
        end
      end
      if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
          i_avs_address == hsfs_pkg::ADDR_CTRL) begin
        next_sw_disable = i_avs_writedata[hsfs_pkg::CTRL_SW_DISABLE];
      end
    end
  end

  // Register the bus slave state.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
      sw_disable <= hsfs_pkg::CTRL_RST;
    end else begin
      o_avs_waitrequest <= next_wait;
      o_avs_readdata <= next_rdata;
      sw_disable <= next_sw_disable;
    end
  end

  // Helper that measures how long the channel stays tripped off.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || state != hsfs_pkg::HSFS_TRIP) begin
      trip_len <= '0;
    end else if (i_clk_en) begin
      trip_len <= trip_len + 1'b1;
    end
  end

  a_limit_cause: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    $rose(state == hsfs_pkg::HSFS_LIMIT) |->
      ($past(state) == hsfs_pkg::HSFS_TRIP) || $past(cle_q))
    else $error("Current limit entered without a qualified overload.");

  a_limit_holds: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    (state == hsfs_pkg::HSFS_LIMIT && cle_q && run && !therm_q) |=> state == hsfs_pkg::HSFS_LIMIT)
    else $error("Clamp released while overload persisted.");

  a_trip_length: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ($past(state) == hsfs_pkg::HSFS_TRIP && state == hsfs_pkg::HSFS_LIMIT) |->
      $past(trip_len) == (TW + 1)'(hsfs_pkg::TRIP_CYC - 1))
    else $error("Fast trip off time has the wrong length.");

  a_thermal_stop: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    (therm_q && is_driving(state)) |=> (state == hsfs_pkg::HSFS_RETRY) ##1 !o_channel_on)
    else $error("Channel kept running through a thermal fault.");

  a_retry_done: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ($past(state) == hsfs_pkg::HSFS_RETRY && state != hsfs_pkg::HSFS_RETRY) |->
      $past(retry_cnt) == '0)
    else $error("Retry wait left before its time ran out.");

  a_abs_cooled: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    ($past(state) == hsfs_pkg::HSFS_RETRY && state != hsfs_pkg::HSFS_RETRY) |->
      (!$past(abs_pend) || $past(below_s)))
    else $error("Absolute shutdown recovered before cooling.");

  a_latched_stays: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    (state == hsfs_pkg::HSFS_LATCHED && en_s && !inhib_fell) |=> !o_channel_on)
    else $error("Latched channel turned on without a toggle.");

  a_fault_report: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    (is_fault(state) && $past(rep_s) && $past(i_clk_en)) |-> (o_fault_flag_n_oe && o_sense_fault_high))
    else $error("Fault state not shown on flag and sense.");

  a_report_hiz: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    !rep_s |=> !o_fault_flag_n_oe && !o_sense_oe && !o_pullup_on)
    else $error("Reporting pins driven with report enable low.");

  a_open_clear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
    (ol_q && !ol_cond) |=> !ol_q)
    else $error("Open-load indication outlived its condition.");

endmodule : hsfs_top

// File: hsfs_host_model.sv
// Host controller pin model: flag input with pull-up and sense input.
// Assumes the design drives the flag as open drain with an enable.
`timescale 1ns/100ps
module hsfs_host_model (
  input wire logic i_flag_data,
  input wire logic i_flag_oe,
  input wire logic i_sense_oe,
  input wire logic i_sense_high,
  output logic o_flag_wire,
  output logic o_sense_level
);
  // The pull-up wins whenever the open-drain driver lets go.
  assign o_flag_wire = i_flag_oe ? i_flag_data : 1'b1;
  // host reads sense
  // A released sense line reads low through the host's load resistor.
  assign o_sense_level = i_sense_oe & i_sense_high;
endmodule : hsfs_host_model

// File: hsfs_top_bench.sv
// Self-checking bench for the high-side switch fault sequencer.
// Assumes the host pin model and shortened open-load and retry counts.
`timescale 1ns/100ps
module hsfs_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, inh = 1'b0, rep = 1'b0, lim = 1'b0, rel = 1'b0, abs_t = 1'b0, hys = 1'b1, ol = 1'b0;
  logic ft = 1'b0;
  logic rd = 1'b0, wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, q;
  logic wreq, chan, clamp, pull, fdat, foe, shigh, soe, fwire, slevel;
  logic [2:0] obs;
  int failures = 0;
  int compares = 0;
  // Levels that the bounded waits poll.
  assign obs = {fwire, clamp, chan};
  // Half period of 4 ns gives 125 MHz.
  always #4 clk = ~clk;
  // Clock enable and byte enables are held on; no scenario freezes the block.
  hsfs_top #(.OPEN_LOAD_CYC(20), .RETRY_CYC(30)) uut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_enable(en), .i_retry_inhibit(inh),
    .i_fault_report_enable(rep), .i_current_limit_event(lim), .i_fast_trip_threshold(ft),
    .i_relative_overtemp(rel), .i_absolute_overtemp(abs_t), .i_below_hysteresis(hys),
    .i_open_load(ol), .i_fault_flag_n(fwire), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_channel_on(chan), .o_current_clamp(clamp), .o_pullup_on(pull),
    .o_fault_flag_n(fdat), .o_fault_flag_n_oe(foe), .o_sense_fault_high(shigh), .o_sense_oe(soe));
  hsfs_host_model host (.i_flag_data(fdat), .i_flag_oe(foe), .i_sense_oe(soe),
    .i_sense_high(shigh), .o_flag_wire(fwire), .o_sense_level(slevel));

  task automatic report_and_stop;
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits are bounded so a stuck design ends the run instead of hanging it.
  task automatic wait_for(input int b, input logic v, input int n_max);
    int n;
    n = 0;
    while (obs[b] !== v && n < n_max) begin
      n++;
      @(posedge clk);
    end
    check({31'h0, obs[b]}, {31'h0, v});
    if (obs[b] !== v) begin
      report_and_stop();
    end
  endtask : wait_for

  // One Avalon access; the extra edge at the end keeps back-to-back calls apart.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wreq !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    check({31'h0, wreq}, 32'h0000_0000);
    if (wreq !== 1'b0) begin
      report_and_stop();
    end
    @(posedge clk);
  endtask : bus

  // Main sequence: registers, overload, thermal retry and latch, open load.
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    check({30'h0, chan, fwire}, 32'h0000_0001);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    check(q, 32'h0000_0000);
    en <= 1'b1;
    rep <= 1'b1;
    wait_for(0, 1'b1, 10);
    repeat (3) @(posedge clk);
    check({30'h0, soe, pull}, 32'h0000_0002);
    bus(1'b0, 4'h4, 32'h0000_0000, q);
    check(q, 32'h0000_0201);
    bus(1'b1, 4'h0, 32'h0000_0001, q);
    wait_for(0, 1'b0, 10);
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    check(q, 32'h0000_0001);
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    wait_for(0, 1'b1, 10);
    ft <= 1'b1;
    lim <= 1'b1;
    wait_for(0, 1'b0, 10);
    ft <= 1'b0;
    wait_for(1, 1'b1, 20);
    repeat (20) @(posedge clk);
    check({30'h0, chan, clamp}, 32'h0000_0003);
    lim <= 1'b0;
    wait_for(1, 1'b0, 10);
    lim <= 1'b1;
    repeat (200) @(posedge clk);
    lim <= 1'b0;
    @(posedge clk);
    lim <= 1'b1;
    repeat (300) @(posedge clk);
    check({31'h0, clamp}, 32'h0000_0000);
    wait_for(1, 1'b1, 40);
    repeat (3) @(posedge clk);
    check({29'h0, chan, fwire, slevel}, 32'h0000_0005);
    rel <= 1'b1;
    wait_for(0, 1'b0, 330);
    rel <= 1'b0;
    lim <= 1'b0;
    repeat (20) @(posedge clk);
    check({30'h0, chan, fwire}, 32'h0000_0000);
    wait_for(0, 1'b1, 30);
    rep <= 1'b0;
    abs_t <= 1'b1;
    hys <= 1'b0;
    wait_for(0, 1'b0, 2600);
    check({30'h0, soe, foe}, 32'h0000_0000);
    abs_t <= 1'b0;
    repeat (60) @(posedge clk);
    check({31'h0, chan}, 32'h0000_0000);
    hys <= 1'b1;
    wait_for(0, 1'b1, 45);
    inh <= 1'b1;
    rel <= 1'b1;
    wait_for(0, 1'b0, 330);
    rel <= 1'b0;
    repeat (80) @(posedge clk);
    check({31'h0, chan}, 32'h0000_0000);
    inh <= 1'b0;
    wait_for(0, 1'b1, 10);
    inh <= 1'b1;
    rel <= 1'b1;
    wait_for(0, 1'b0, 330);
    rel <= 1'b0;
    repeat (80) @(posedge clk);
    en <= 1'b0;
    repeat (6) @(posedge clk);
    en <= 1'b1;
    wait_for(0, 1'b1, 10);
    rel <= 1'b1;
    wait_for(0, 1'b0, 330);
    rel <= 1'b0;
    repeat (80) @(posedge clk);
    check({31'h0, chan}, 32'h0000_0000);
    en <= 1'b0;
    rep <= 1'b1;
    wait_for(0, 1'b0, 10);
    repeat (4) @(posedge clk);
    check({31'h0, pull}, 32'h0000_0001);
    ol <= 1'b1;
    repeat (10) @(posedge clk);
    check({31'h0, fwire}, 32'h0000_0001);
    wait_for(2, 1'b0, 30);
    check({31'h0, slevel}, 32'h0000_0001);
    ol <= 1'b0;
    wait_for(2, 1'b1, 10);
    rep <= 1'b0;
    repeat (4) @(posedge clk);
    check({29'h0, soe, foe, pull}, 32'h0000_0000);
    report_and_stop();
  end
endmodule : hsfs_top_bench
